/* adc_regs.vh */
`ifndef ADC_REGS_VH
`define ADC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define RESULT_OFS 8'h00
`define CTRL_OFS 8'h20
`define STATUS_OFS 8'h80
`define MASK_OFS 8'h84

// ****************************************
// reset values
// ****************************************
`define CTRL_RST 32'h00000000
`define STATUS_RST 2'h0
`define MASK_RST 2'h3

// ****************************************
// conversion result fields
// ****************************************
`define RES_VALID_BIT 17
`define RES_OVR_BIT 16
`define RES_DATA_MSB 11
`define RES_WIDTH 12

// ****************************************
// converter control fields
// ****************************************
`define CTRL_START_BIT 11
`define CTRL_HWEN_BIT 8
`define CTRL_EDGE_BIT 6
`define CTRL_SRC_MSB 5
`define CTRL_SRC_LSB 4
`define CTRL_IEN_BIT 1
`define CTRL_EN_BIT 0
`define CTRL_WMASK 32'h00000973
`define SRC_PIN 2'h0
`define SRC_PWM 2'h3

// ****************************************
// interrupt status and mask fields
// ****************************************
`define STAT_END_BIT 0
`define STAT_OVR_BIT 1
`define STAT_WIDTH 2

// ****************************************
// timing and bus answers
// ****************************************
`define PIN_STABLE_CLKS 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* start_pin_filter.v */
`timescale 1ns/1ps
`include "adc_regs.vh"

module start_pin_filter #(
	parameter STABLE = `PIN_STABLE_CLKS
) (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// pin and edge choice
	input wire pin_i,
	input wire rising_sel_i,
	// qualified edge
	output wire edge_o
);

reg sync1_q;
reg sync2_q;
reg [STABLE-1:0] hist_q;
reg level_q;
reg primed_q;
reg edge_q;
wire all_high;
wire all_low;

assign all_high = &hist_q;
assign all_low = ~|hist_q;
assign edge_o = edge_q;

// ****************************************
// synchronise, filter, detect edge
// ****************************************
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		sync1_q <= 1'b0;
		sync2_q <= 1'b0;
		hist_q <= {STABLE{1'b0}};
		level_q <= 1'b0;
		primed_q <= 1'b0;
		edge_q <= 1'b0;
	end else begin
		sync1_q <= pin_i;
		sync2_q <= sync1_q;
		hist_q <= {hist_q[STABLE-2:0], sync2_q};
		edge_q <= 1'b0;
		// first settled level after reset only primes
		if (all_high && (!level_q || !primed_q)) begin
			level_q <= 1'b1;
			primed_q <= 1'b1;
			edge_q <= primed_q & rising_sel_i;
		end else if (all_low && (level_q || !primed_q)) begin
			level_q <= 1'b0;
			primed_q <= 1'b1;
			edge_q <= primed_q & ~rising_sel_i;
		end
	end
end

endmodule

/* result_capture.v */
`timescale 1ns/1ps
`include "adc_regs.vh"

module result_capture (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// new result from converter
	input wire load_i,
	input wire [`RES_WIDTH-1:0] data_i,
	// read of the result register
	input wire clear_i,
	// held result and flags
	output wire [`RES_WIDTH-1:0] data_o,
	output wire valid_o,
	output wire ovr_o
);

reg [`RES_WIDTH-1:0] data_q;
reg valid_q;
reg ovr_q;

assign data_o = data_q;
assign valid_o = valid_q;
assign ovr_o = ovr_q;

// ****************************************
// result hold, load wins over read clear
// ****************************************
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		data_q <= {`RES_WIDTH{1'b0}};
		valid_q <= 1'b0;
		ovr_q <= 1'b0;
	end else begin
		if (load_i) begin
			data_q <= data_i;
			valid_q <= 1'b1;
			// a read in the load cycle already reported the old flags
			ovr_q <= (ovr_q | valid_q) & ~clear_i;
		end else if (clear_i) begin
			valid_q <= 1'b0;
			ovr_q <= 1'b0;
		end
	end
end

endmodule

/* adc_ctrl_top.v */
// Overview of operation
// - valid set on result, cleared by read
// - overrun when unread result overwritten; read clears
// - 12-bit result in low bits, valid at bit 17, overrun at bit 16, rest zero
// - start bit set by software, pin or PWM
// - start bit auto-clears; zero means converter idle
// - hardware trigger honoured only when enabled
// - edge select: zero falling, one rising
// - source 00 pin, 11 PWM, others none
// - end interrupt only with interrupt enable set
// - enable zero powers down converter
// - end flag set on completion drives interrupt
`timescale 1ns/1ps
`include "adc_regs.vh"

module adc_ctrl_top (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// axi4-lite write address
	input wire awvalid_i,
	output wire awready_o,
	input wire [7:0] awaddr_i,
	input wire [2:0] awprot_i,
	// axi4-lite write data
	input wire wvalid_i,
	output wire wready_o,
	input wire [31:0] wdata_i,
	input wire [3:0] wstrb_i,
	// axi4-lite write response
	output wire bvalid_o,
	input wire bready_i,
	output wire [1:0] bresp_o,
	// axi4-lite read address
	input wire arvalid_i,
	output wire arready_o,
	input wire [7:0] araddr_i,
	input wire [2:0] arprot_i,
	// axi4-lite read data
	output wire rvalid_o,
	input wire rready_i,
	output wire [31:0] rdata_o,
	output wire [1:0] rresp_o,
	// triggers
	input wire start_pin_i,
	input wire pwm_trig_i,
	// analog converter core
	output wire conv_power_o,
	output wire conv_run_o,
	input wire conv_done_i,
	input wire [`RES_WIDTH-1:0] conv_data_i,
	// interrupt
	output wire irq_o
);

// ****************************************
// declarations
// ****************************************
reg awready_q;
reg aw_held_q;
reg [7:0] awaddr_q;
reg wready_q;
reg w_held_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg arready_q;
reg rvalid_q;
reg [31:0] rdata_q;
reg [1:0] rresp_q;
reg [31:0] ctrl_q;
reg start_q;
reg active_q;
reg power_q;
reg [`STAT_WIDTH-1:0] status_q;
reg [`STAT_WIDTH-1:0] mask_q;
reg irq_q;
reg [31:0] rd_word;
reg rd_hit;
wire [31:0] byte_mask;
wire [31:0] ctrl_mask;
wire do_write;
wire wr_ctrl;
wire wr_status;
wire wr_mask;
wire wr_hit;
wire rd_take;
wire rd_clear;
wire pin_edge;
wire hw_trig;
wire sw_set;
wire sw_clear;
wire done_take;
wire new_ovr;
wire [`RES_WIDTH-1:0] res_data;
wire res_valid;
wire res_ovr;
wire [`STAT_WIDTH-1:0] stat_set;
wire [`STAT_WIDTH-1:0] stat_clr;
wire [`STAT_WIDTH-1:0] irq_gate;

assign awready_o = awready_q;
assign wready_o = wready_q;
assign bvalid_o = bvalid_q;
assign bresp_o = bresp_q;
assign arready_o = arready_q;
assign rvalid_o = rvalid_q;
assign rdata_o = rdata_q;
assign rresp_o = rresp_q;
assign conv_power_o = power_q;
assign conv_run_o = active_q;
assign irq_o = irq_q;

// ****************************************
// trigger pin and result holder
// ****************************************
start_pin_filter #(
	.STABLE(`PIN_STABLE_CLKS)
) u_pin (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.pin_i(start_pin_i),
	.rising_sel_i(ctrl_q[`CTRL_EDGE_BIT]),
	.edge_o(pin_edge)
);

result_capture u_result (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.load_i(done_take),
	.data_i(conv_data_i),
	.clear_i(rd_clear),
	.data_o(res_data),
	.valid_o(res_valid),
	.ovr_o(res_ovr)
);

// ****************************************
// write channel decode
// ****************************************
assign do_write = aw_held_q & w_held_q & ~bvalid_q;
assign wr_ctrl = do_write & (awaddr_q == `CTRL_OFS);
assign wr_status = do_write & (awaddr_q == `STATUS_OFS);
assign wr_mask = do_write & (awaddr_q == `MASK_OFS);
assign wr_hit = (awaddr_q == `CTRL_OFS) | (awaddr_q == `STATUS_OFS) |
	(awaddr_q == `MASK_OFS) | (awaddr_q == `RESULT_OFS);
assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
	{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
assign ctrl_mask = byte_mask & `CTRL_WMASK;

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		awready_q <= 1'b1;
		aw_held_q <= 1'b0;
		awaddr_q <= 8'h00;
		wready_q <= 1'b1;
		w_held_q <= 1'b0;
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
		bvalid_q <= 1'b0;
		bresp_q <= `RESP_OKAY;
	end else begin
		if (awvalid_i && awready_q) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b1;
			awaddr_q <= {awaddr_i[7:2], 2'b00};
		end
		if (wvalid_i && wready_q) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b1;
			wdata_q <= wdata_i;
			wstrb_q <= wstrb_i;
		end
		if (do_write) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_q && bready_i) begin
			bvalid_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
		end
	end
end

// ****************************************
// read channel
// ****************************************
assign rd_take = arvalid_i & arready_q;
assign rd_clear = rd_take & ({araddr_i[7:2], 2'b00} == `RESULT_OFS);

always @* begin
	rd_word = 32'h00000000;
	rd_hit = 1'b1;
	case ({araddr_i[7:2], 2'b00})
	`RESULT_OFS: begin
		rd_word[`RES_DATA_MSB:0] = res_data;
		rd_word[`RES_VALID_BIT] = res_valid;
		rd_word[`RES_OVR_BIT] = res_ovr;
	end
	`CTRL_OFS: begin
		rd_word = ctrl_q & `CTRL_WMASK;
		rd_word[`CTRL_START_BIT] = start_q;
	end
	`STATUS_OFS: begin
		rd_word[`STAT_WIDTH-1:0] = status_q;
	end
	`MASK_OFS: begin
		rd_word[`STAT_WIDTH-1:0] = mask_q;
	end
	default: begin
		rd_hit = 1'b0;
	end
	endcase
end

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		arready_q <= 1'b1;
		rvalid_q <= 1'b0;
		rdata_q <= 32'h00000000;
		rresp_q <= `RESP_OKAY;
	end else begin
		if (rd_take) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_q && rready_i) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end
end

// ****************************************
// trigger selection
// ****************************************
assign hw_trig = ctrl_q[`CTRL_HWEN_BIT] & (
	((ctrl_q[`CTRL_SRC_MSB:`CTRL_SRC_LSB] == `SRC_PIN) & pin_edge) |
	((ctrl_q[`CTRL_SRC_MSB:`CTRL_SRC_LSB] == `SRC_PWM) & pwm_trig_i));
assign sw_set = wr_ctrl & wstrb_q[1] & wdata_q[`CTRL_START_BIT];
assign sw_clear = wr_ctrl & wstrb_q[1] & ~wdata_q[`CTRL_START_BIT];
assign done_take = conv_done_i & active_q;

// ****************************************
// control register and conversion sequence
// ****************************************
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		ctrl_q <= `CTRL_RST;
		start_q <= 1'b0;
		active_q <= 1'b0;
		power_q <= 1'b0;
	end else begin
		if (wr_ctrl) begin
			ctrl_q <= (ctrl_q & ~ctrl_mask) | (wdata_q & ctrl_mask);
		end
		power_q <= ctrl_q[`CTRL_EN_BIT];
		if (!ctrl_q[`CTRL_EN_BIT]) begin
			// disabled converter holds no pending start
			start_q <= 1'b0;
			active_q <= 1'b0;
		end else if (sw_set || hw_trig) begin
			start_q <= 1'b1;
			if (done_take) begin
				active_q <= 1'b0;
			end
		end else if (sw_clear) begin
			start_q <= 1'b0;
			active_q <= 1'b0;
		end else if (done_take) begin
			start_q <= 1'b0;
			active_q <= 1'b0;
		end else if (start_q && !active_q) begin
			active_q <= 1'b1;
		end
	end
end

// ****************************************
// interrupt status, mask and output
// ****************************************
assign new_ovr = done_take & res_valid & ~rd_clear;
assign stat_set = {new_ovr, done_take};
assign stat_clr = wr_status ? wdata_q[`STAT_WIDTH-1:0] & byte_mask[1:0] :
	{`STAT_WIDTH{1'b0}};
assign irq_gate = {1'b1, ctrl_q[`CTRL_IEN_BIT]};

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		status_q <= `STATUS_RST;
		mask_q <= `MASK_RST;
		irq_q <= 1'b0;
	end else begin
		status_q <= (status_q & ~stat_clr) | stat_set;
		if (wr_mask && wstrb_q[0]) begin
			mask_q <= wdata_q[`STAT_WIDTH-1:0];
		end
		irq_q <= |(status_q & mask_q & irq_gate);
	end
end

endmodule

/* conv_core_model.sv */
`timescale 1ns/1ps

module conv_core_model (
	// clock
	input wire clk_i,
	// run request and result to hand back
	input wire run_i,
	input wire [11:0] data_i,
	// completion and result lines
	output logic done_o = 1'h0,
	output logic [11:0] data_o = 12'h0
);
	logic [1:0] cnt_q = 2'h0;
	logic fin;
	assign fin = run_i && !done_o && cnt_q == 2'h3;
	// data toggles outside the done cycle
	always @(posedge clk_i) begin
		cnt_q <= (run_i && !done_o) ? cnt_q + 2'h1 : 2'h0;
		done_o <= fin;
		data_o <= fin ? data_i : ~data_o;
	end
endmodule

/* adc_ctrl_props.sv */
`timescale 1ns/1ps
`include "adc_regs.vh"

module adc_ctrl_props (
	// clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// register bus
	input wire awvalid_i,
	input wire awready_o,
	input wire wvalid_i,
	input wire wready_o,
	input wire bvalid_o,
	input wire bready_i,
	input wire arvalid_i,
	input wire arready_o,
	input wire [7:0] araddr_i,
	input wire rvalid_o,
	input wire rready_i,
	input wire [31:0] rdata_o,
	input wire [1:0] rresp_o,
	// converter core
	input wire conv_power_o,
	input wire conv_run_o,
	input wire conv_done_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	run_power_a:
	assert property (conv_run_o |-> conv_power_o)
	else $error("run without power");
	done_stop_a:
	assert property (conv_run_o && conv_done_i |=> !conv_run_o)
	else $error("run kept after done");
	rsvd_zero_a:
	assert property (rvalid_o |-> rdata_o[31:18] == 14'h0
		&& rdata_o[15:12] == 4'h0)
	else $error("reserved bits set");
	wr_answer_a:
	assert property (awvalid_i && awready_o && wvalid_i && wready_o
		|=> ##1 bvalid_o)
	else $error("no write answer");
	rd_answer_a:
	assert property (arvalid_i && arready_o |=> rvalid_o)
	else $error("no read answer");
	rd_hold_a:
	assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
	else $error("read data dropped");
	wr_hold_a:
	assert property (bvalid_o && !bready_i |=> bvalid_o)
	else $error("write answer dropped");
	bad_addr_a:
	assert property (arvalid_i && arready_o && !({araddr_i[7:2], 2'h0}
		inside {`RESULT_OFS, `CTRL_OFS, `STATUS_OFS, `MASK_OFS})
		|=> rresp_o == `RESP_SLVERR && rdata_o == 32'h0)
	else $error("unmapped read accepted");
endmodule

bind adc_ctrl_top adc_ctrl_props u_props (.*);

/* adc_data_and_control_regs_bench.sv */
`timescale 1ns/1ps
`include "adc_regs.vh"

module adc_data_and_control_regs_bench;
	logic clk_i = 1'h0, rst_n_i = 1'h0, awvalid_i = 1'h0, wvalid_i = 1'h0;
	logic bready_i = 1'h0, arvalid_i = 1'h0, rready_i = 1'h0;
	logic start_pin_i = 1'h1, pwm_trig_i = 1'h0;
	logic [7:0] awaddr_i = 8'h0, araddr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, v;
	logic [2:0] awprot_i = 3'h0, arprot_i = 3'h0;
	logic [3:0] wstrb_i = 4'hF;
	logic [1:0] bresp_o, rresp_o, resp;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
	logic conv_power_o, conv_run_o, conv_done_i;
	logic [11:0] conv_data_i, cdata = 12'hABC;
	int miscompares = 0, comparisons = 0;

	adc_ctrl_top u_dut (.*);
	conv_core_model u_core (.clk_i(clk_i), .run_i(conv_run_o),
		.data_i(cdata), .done_o(conv_done_i), .data_o(conv_data_i));

	initial forever #10 clk_i = ~clk_i;

	// ****************
	// bus and checks
	// ****************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'h1;
		wvalid_i <= 1'h1;
		// answer accepted a cycle late so it must stand
		do begin
			@(posedge clk_i);
			if (awready_o) awvalid_i <= 1'h0;
			if (wready_o) wvalid_i <= 1'h0;
			if (bvalid_o && !bready_i) bready_i <= 1'h1;
		end while (!(bvalid_o && bready_i));
		resp = bresp_o;
		bready_i <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1'h1;
		do begin
			@(posedge clk_i);
			if (arready_o) arvalid_i <= 1'h0;
			if (rvalid_o && !rready_i) rready_i <= 1'h1;
		end while (!(rvalid_o && rready_i));
		v = rdata_o;
		resp = rresp_o;
		rready_i <= 1'h0;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		cmp(v, e);
	endtask
	// run seen within the window or not
	task automatic conv(input logic e);
		logic seen;
		seen = 1'h0;
		repeat (40) begin
			@(posedge clk_i);
			if (conv_run_o) seen = 1'h1;
		end
		cmp({31'h0, seen}, {31'h0, e});
	endtask
	task automatic flags(input logic [1:0] e);
		repeat (3) @(posedge clk_i);
		cmp({30'h0, irq_o, conv_power_o}, {30'h0, e});
	endtask
	task automatic pin(input logic l, input logic e);
		start_pin_i <= l;
		conv(e);
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_regs;
		chk(`CTRL_OFS, 32'h0);
		chk(`RESULT_OFS, 32'h0);
		chk(`MASK_OFS, 32'h3);
		chk(8'h40, 32'h0);
		cmp({30'h0, resp}, {30'h0, `RESP_SLVERR});
		wr(`CTRL_OFS, 32'hFFFFF672);
		chk(`CTRL_OFS, 32'h72);
		wr(`RESULT_OFS, 32'hFFF);
		cmp({30'h0, resp}, {30'h0, `RESP_OKAY});
		chk(`RESULT_OFS, 32'h0);
		wr(8'h40, 32'h1);
		cmp({30'h0, resp}, {30'h0, `RESP_SLVERR});
		$display("end regs");
	endtask
	task automatic t_sw;
		wr(`CTRL_OFS, 32'h3);
		wr(`CTRL_OFS, 32'h803);
		conv(1'h1);
		flags(2'h3);
		chk(`RESULT_OFS, 32'h20ABC);
		chk(`RESULT_OFS, 32'hABC);
		chk(`CTRL_OFS, 32'h3);
		chk(`STATUS_OFS, 32'h1);
		wr(`STATUS_OFS, 32'h1);
		flags(2'h1);
		$display("end sw");
	endtask
	task automatic t_ovr;
		wr(`CTRL_OFS, 32'h801);
		conv(1'h1);
		flags(2'h1);
		cdata <= 12'h5A0;
		wr(`CTRL_OFS, 32'h801);
		conv(1'h1);
		flags(2'h3);
		wr(`MASK_OFS, 32'h0);
		flags(2'h1);
		wr(`MASK_OFS, 32'h3);
		flags(2'h3);
		chk(`RESULT_OFS, 32'h305A0);
		chk(`RESULT_OFS, 32'h5A0);
		wr(`STATUS_OFS, 32'h3);
		flags(2'h1);
		$display("end ovr");
	endtask
	task automatic t_pin;
		wr(`CTRL_OFS, 32'h101);
		pin(1'h0, 1'h1);
		pin(1'h1, 1'h0);
		wr(`CTRL_OFS, 32'h141);
		pin(1'h0, 1'h0);
		pin(1'h1, 1'h1);
		start_pin_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		pin(1'h1, 1'h0);
		wr(`CTRL_OFS, 32'h41);
		pin(1'h0, 1'h0);
		pin(1'h1, 1'h0);
		$display("end pin");
	endtask
	task automatic t_pwm;
		for (int s = 0; s < 4; s++) begin
			wr(`CTRL_OFS, 32'h101 | (s << 4));
			pwm_trig_i <= 1'h1;
			@(posedge clk_i);
			pwm_trig_i <= 1'h0;
			conv(s == 3);
		end
		$display("end pwm");
	endtask
	task automatic t_off;
		wr(`STATUS_OFS, 32'h3);
		wr(`CTRL_OFS, 32'h0);
		flags(2'h0);
		wr(`CTRL_OFS, 32'h800);
		conv(1'h0);
		chk(`CTRL_OFS, 32'h0);
		$display("end off");
	endtask

	task automatic close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		t_regs;
		t_sw;
		t_ovr;
		t_pin;
		t_pwm;
		t_off;
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		close_out;
	end
endmodule
